// file: bench/mtmr_dma_sink.sv
/* mtmr_dma_sink: dma channel stand-in counting transfer requests.
   assumes: requests are one-cycle pulses on mclk_i. */
`timescale 1ns/1ps
module mtmr_dma_sink (
    // clock and reset
    input  wire logic mclk_i,
    input  wire logic srst_i,
    // request in, count out
    input  wire logic dma_req_i,
    output int        n_req_o
);
    // every pulse is one accepted transfer, no backpressure exists
    always_ff @(posedge mclk_i) begin
        if (srst_i) n_req_o <= 0;
        else if (dma_req_i) n_req_o <= n_req_o + 1;
    end
endmodule : mtmr_dma_sink

// file: bench/mtmr_props.sv
/* mtmr_props: port checker for mtmr_top.
   assumes: bound to every mtmr_top, single clock mclk_i. */
`timescale 1ns/1ps
module mtmr_props
    import mtmr_pkg::*;
(
    // watched ports
    input wire logic        mclk_i,
    input wire logic        srst_i,
    input wire logic [4:0]  avs_address_i,
    input wire logic        avs_read_i,
    input wire logic        avs_write_i,
    input wire logic [31:0] avs_readdata_o,
    input wire logic        avs_waitrequest_o,
    input wire logic        standby_i,
    input wire logic        dma_req_o,
    input wire logic        irq_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (srst_i);
    // read completes where waitrequest is low
    wire rd_done = avs_read_i && !avs_waitrequest_o;
    wire busy = avs_read_i | avs_write_i;
    property p_wfirst; $rose(busy) |-> avs_waitrequest_o; endproperty
    a_wfirst: assert property (p_wfirst) else $error("no wait state");
    property p_wsecond; busy && avs_waitrequest_o |=> !avs_waitrequest_o; endproperty
    a_wsecond: assert property (p_wsecond) else $error("wait too long");
    property p_unmap; rd_done && avs_address_i > OFS_IRQ_MSK |-> avs_readdata_o == 32'h0; endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
    property p_srsv; rd_done && avs_address_i == OFS_START |-> avs_readdata_o[31:2] == 30'h0; endproperty
    a_srsv: assert property (p_srsv) else $error("start high bits set");
    property p_crsv; rd_done && avs_address_i == OFS_CSR |-> !avs_readdata_o[31:8] && !avs_readdata_o[5:2];
    endproperty
    a_crsv: assert property (p_crsv) else $error("csr reserved bits set");
    // fastest setting still ticks only every 4 clocks
    property p_gap; dma_req_o |=> !dma_req_o [*3]; endproperty
    a_gap: assert property (p_gap) else $error("requests too close");
    property p_stby; standby_i [*3] |-> !dma_req_o; endproperty
    a_stby: assert property (p_stby) else $error("request in standby");
    property p_rst; disable iff (1'b0) srst_i |=> !dma_req_o && !irq_o; endproperty
    a_rst: assert property (p_rst) else $error("outputs live after reset");
    c_dma: cover property (dma_req_o);
    c_flag: cover property (rd_done && avs_address_i == OFS_CSR && avs_readdata_o[7]);
    c_irq: cover property (irq_o ##1 !irq_o);
endmodule : mtmr_props

bind mtmr_top mtmr_props u_props (.mclk_i(mclk_i), .srst_i(srst_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .standby_i(standby_i), .dma_req_o(dma_req_o), .irq_o(irq_o));

// file: bench/test_dma_request_compare_timer.sv
/* test_dma_request_compare_timer: directed bench for mtmr_top.
   assumes: mtmr_props and mtmr_dma_sink compiled before it. */
`timescale 1ns/1ps
module test_dma_request_compare_timer;
    import mtmr_pkg::*;
    logic        mclk_i = 0;
    logic        srst_i = 1;
    logic        stby = 0;
    mtmr_req_s   req = '0;
    logic [31:0] rdata, bd;
    logic        wait_o, dma_o, irq_o;
    int          failures = 0, n_tests = 0, cyc = 0, n_req;
    mtmr_top dut (.mclk_i(mclk_i), .srst_i(srst_i), .avs_address_i(req.address), .avs_read_i(req.read),
        .avs_write_i(req.write), .avs_writedata_i(req.writedata), .avs_readdata_o(rdata),
        .avs_waitrequest_o(wait_o), .standby_i(stby), .dma_req_o(dma_o), .irq_o(irq_o));
    mtmr_dma_sink sink (.mclk_i(mclk_i), .srst_i(srst_i), .dma_req_i(dma_o), .n_req_o(n_req));
    // 25 MHz clock
    initial forever #20 mclk_i = ~mclk_i;
    // hang guard, run needs under 1000 cycles
    always @(posedge mclk_i) if (++cyc == 20000) begin
        failures++;
        print_verdict();
    end
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : print_verdict
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            failures++;
            $display("[ERR] %s exp %h got %h", nm, e, g);
        end
    endtask : chk
    // one avalon transfer, held until waitrequest is seen low
    task automatic bus(input logic [4:0] a, input logic w, input logic [31:0] d);
        @(posedge mclk_i);
        req <= '{a, !w, w, d};
        do @(posedge mclk_i); while (wait_o !== 1'b0);
        bd = rdata;
        req <= '{a, 1'b0, 1'b0, d};
    endtask : bus
    task automatic rc(input logic [4:0] a, input logic [31:0] e, input string nm);
        bus(a, 1'b0, 32'h0);
        chk(nm, e, bd);
    endtask : rc
    task automatic t_reset();
        rc(OFS_START, 32'h0, "start");
        rc(OFS_CSR, 32'h0, "csr");
        rc(OFS_COUNT, 32'h0, "count");
        rc(OFS_CONST, 32'h0000FFFF, "const");
        rc(5'h18, 32'h0, "unmapped");
    endtask : t_reset
    task automatic t_fields();
        bus(5'h18, 1'b1, 32'h0000FFFF);
        bus(OFS_START, 1'b1, 32'h0000FFFE);
        rc(OFS_START, 32'h2, "start rsv");
        bus(OFS_START, 1'b1, 32'h0);
        bus(OFS_CSR, 1'b1, 32'h0000FFFF);
        rc(OFS_CSR, 32'h43, "csr rsv");
        bus(OFS_CSR, 1'b1, 32'h0);
    endtask : t_fields
    // period is (const + 1) ticks for every clock select code
    task automatic t_match();
        int n;
        bus(OFS_CONST, 1'b1, 32'h2);
        bus(OFS_IRQ_MSK, 1'b1, 32'h1);
        for (int k = 0; k < 4; k++) begin
            bus(OFS_CSR, 1'b1, 32'(k));
            bus(OFS_START, 1'b1, 32'h1);
            n = 0;
            while (dma_o !== 1'b1) @(posedge mclk_i);
            do begin @(posedge mclk_i); n++; end while (dma_o !== 1'b1);
            chk("period", 3 * ((k == 3) ? 64 : 4 << k), n);
            bus(OFS_START, 1'b1, 32'h0);
        end
        @(posedge mclk_i);
        chk("irq set", 1, irq_o);
        bus(OFS_CSR, 1'b1, 32'h0);
        rc(OFS_CSR, 32'h80, "flag unread");
        bus(OFS_CSR, 1'b1, 32'h80);
        rc(OFS_CSR, 32'h80, "flag w1");
        bus(OFS_CSR, 1'b1, 32'h0);
        rc(OFS_CSR, 32'h0, "flag clr");
        bus(OFS_IRQ_MSK, 1'b1, 32'h0);
        @(posedge mclk_i);
        chk("irq mask", 0, irq_o);
        bus(OFS_IRQ_MSK, 1'b1, 32'h1);
        bus(OFS_IRQ_ST, 1'b1, 32'h1);
        @(posedge mclk_i);
        chk("irq clr", 0, irq_o);
    endtask : t_match
    // wrap at the top, then standby freezes count and requests; 16 clocks give 4 ticks
    task automatic t_standby();
        int          m;
        logic [31:0] v;
        bus(OFS_CONST, 1'b1, 32'h0000FFFF);
        bus(OFS_COUNT, 1'b1, 32'h0000FFFE);
        m = n_req;
        bus(OFS_START, 1'b1, 32'h1);
        repeat (16) @(posedge mclk_i);
        chk("wrap request", m + 1, n_req);
        stby <= 1'b1;
        bus(OFS_COUNT, 1'b0, 32'h0);
        v = bd;
        chk("count hi", 32'h0, {16'h0, v[31:16]});
        m = n_req;
        repeat (100) @(posedge mclk_i);
        chk("dma in standby", m, n_req);
        rc(OFS_COUNT, v, "count held");
        rc(OFS_CONST, 32'h0000FFFF, "const held");
        stby <= 1'b0;
        repeat (15) @(posedge mclk_i);
        rc(OFS_COUNT, v + 32'h4, "count resumes");
        bus(OFS_START, 1'b1, 32'h0);
    endtask : t_standby
    initial begin
        repeat (16) @(posedge mclk_i);
        srst_i <= 1'b0;
        t_reset();
        t_fields();
        t_match();
        t_standby();
        print_verdict();
    end
endmodule : test_dma_request_compare_timer

// file: src/mtmr_pkg.sv
/*
 * mtmr_pkg: register map, field positions, reset values and divider
 * settings for the dma request compare match timer.
 * assumes: 32-bit avalon-mm word bus, one register per aligned word.
 */
package mtmr_pkg;
    // register byte offsets (avalon word aligned)
    localparam logic [4:0] OFS_START   = 5'h00;
    localparam logic [4:0] OFS_CSR     = 5'h04;
    localparam logic [4:0] OFS_COUNT   = 5'h08;
    localparam logic [4:0] OFS_CONST   = 5'h0C;
    localparam logic [4:0] OFS_IRQ_ST  = 5'h10;
    localparam logic [4:0] OFS_IRQ_MSK = 5'h14;

    // field positions
    localparam int RUN_BIT     = 0;
    localparam int START_RSV   = 1;
    localparam int FLAG_BIT    = 7;
    localparam int CSR_RSV     = 6;
    localparam int CKS_LO      = 0;
    localparam int CKS_HI      = 1;

    // reset values
    localparam logic [15:0] COUNT_RST = 16'h0000;
    localparam logic [15:0] CONST_RST = 16'hFFFF;

    // prescale terminal counts (divide ratio minus one) per clock select code
    localparam logic [5:0] DIV_4  = 6'h03;
    localparam logic [5:0] DIV_8  = 6'h07;
    localparam logic [5:0] DIV_16 = 6'h0F;
    localparam logic [5:0] DIV_64 = 6'h3F;

    localparam logic [1:0] CKS_D4  = 2'h0;
    localparam logic [1:0] CKS_D8  = 2'h1;
    localparam logic [1:0] CKS_D16 = 2'h2;
    localparam logic [1:0] CKS_D64 = 2'h3;

    // interrupt status bit positions
    localparam int IRQ_MATCH = 0;

    // bus request carrier
    typedef struct packed {
        logic [4:0]  address;
        logic        read;
        logic        write;
        logic [31:0] writedata;
    } mtmr_req_s;
endpackage : mtmr_pkg

// file: src/mtmr_top.sv
/*
 * mtmr_top: 16-bit compare match timer raising dma transfer requests,
 * with avalon-mm register slave and a masked match interrupt.
 * assumes: single clock mclk_i, synchronous active high reset; the dma
 * channel logic takes dma_req_o as a one-cycle pulse per match.
 */

`timescale 1ns/1ps
module mtmr_top
    import mtmr_pkg::*;
#(
    parameter int CNT_W = 16
) (
    // clock and reset
    input  wire logic        mclk_i,
    input  wire logic        srst_i,
    // avalon-mm slave
    input  wire logic [4:0]  avs_address_i,
    input  wire logic        avs_read_i,
    input  wire logic        avs_write_i,
    input  wire logic [31:0] avs_writedata_i,
    output logic [31:0]      avs_readdata_o,
    output logic             avs_waitrequest_o,
    // power and system
    input  wire logic        standby_i,
    // dma side and interrupt
    output logic             dma_req_o,
    output logic             irq_o
);
    mtmr_req_s req;

    // register state
    logic             run_bit;
    logic             start_rsv;
    logic             flag;
    logic             csr_rsv;
    logic [1:0]       cks;
    logic [CNT_W-1:0] count;
    logic [CNT_W-1:0] cmp_const;
    logic             flag_seen;
    logic             irq_st;
    logic             irq_msk;
    // prescaler, handshake and request
    logic [5:0]       pre;
    logic             ack;
    logic             dma_req;
    // read path words
    logic [31:0]      rdata;
    logic [31:0]      start_word;
    logic [31:0]      csr_word;
    logic [31:0]      count_word;
    logic [31:0]      const_word;
    logic [31:0]      ist_word;
    logic [31:0]      imsk_word;

    // bundle the bus request
    assign req = '{address: avs_address_i, read: avs_read_i,
                   write: avs_write_i, writedata: avs_writedata_i};

    // one wait state per access: answer on the cycle after the request;
    // a master that holds its request past the answer starts a new one
    wire busy     = req.read | req.write;
    wire access   = busy & ~ack;
    assign avs_waitrequest_o = access;

    // address decode shared by the read and write paths
    wire sel_start = (req.address == OFS_START);
    wire sel_csr   = (req.address == OFS_CSR);
    wire sel_count = (req.address == OFS_COUNT);
    wire sel_const = (req.address == OFS_CONST);
    wire sel_ist   = (req.address == OFS_IRQ_ST);
    wire sel_imsk  = (req.address == OFS_IRQ_MSK);

    // writes land on the answer cycle only, so each request takes effect once
    wire wr_ok    = ack & req.write;
    wire wr_start = wr_ok & sel_start;
    wire wr_csr   = wr_ok & sel_csr;
    wire wr_count = wr_ok & sel_count;
    wire wr_const = wr_ok & sel_const;
    wire wr_ist   = wr_ok & sel_ist;
    wire wr_imsk  = wr_ok & sel_imsk;
    // the flag is judged where the read data is captured, so a match landing
    // between capture and answer cannot arm a clear that software never saw
    wire rd_csr   = access & req.read & sel_csr;

    // prescaler terminal count per clock select
    wire [5:0] div_top = (cks == CKS_D4)  ? DIV_4  :
                         (cks == CKS_D8)  ? DIV_8  :
                         (cks == CKS_D16) ? DIV_16 : DIV_64;
    // tick only while running and not in standby, so standby freezes state
    wire counting = run_bit & ~standby_i;
    wire tick     = counting & (pre >= div_top);
    // equality is held until the next tick, which then performs the clear;
    // clearing at equality would shorten every period by one tick
    wire at_match = (count == cmp_const);
    wire match    = tick & at_match;
    wire [CNT_W-1:0] count_inc  = count + 1'b1;
    wire [CNT_W-1:0] next_count = match ? COUNT_RST[CNT_W-1:0] : count_inc;
    wire [5:0]       next_pre   = tick ? 6'h00 : pre + 6'h01;

    // flag clear needs a read of 1 beforehand and a written 0;
    // writing a 1, or writing without that read, leaves the flag alone
    wire flag_clr = wr_csr & flag_seen & ~req.writedata[FLAG_BIT];
    // interrupt status is write-one-to-clear
    wire irq_clr  = wr_ist & req.writedata[IRQ_MATCH];

    // start word built field by field; any bit not listed reads zero
    always_comb begin
        start_word            = 32'h0000_0000;
        start_word[RUN_BIT]   = run_bit;
        start_word[START_RSV] = start_rsv;
    end

    // control/status word: flag, reserved bit and clock select
    always_comb begin
        csr_word                = 32'h0000_0000;
        csr_word[FLAG_BIT]      = flag;
        csr_word[CSR_RSV]       = csr_rsv;
        csr_word[CKS_HI:CKS_LO] = cks;
    end

    // counter and constant sit in the low half, upper half zero
    always_comb begin
        count_word            = 32'h0000_0000;
        count_word[CNT_W-1:0] = count;
    end

    always_comb begin
        const_word            = 32'h0000_0000;
        const_word[CNT_W-1:0] = cmp_const;
    end

    // interrupt status and mask share the match bit position
    always_comb begin
        ist_word            = 32'h0000_0000;
        ist_word[IRQ_MATCH] = irq_st;
    end

    always_comb begin
        imsk_word            = 32'h0000_0000;
        imsk_word[IRQ_MATCH] = irq_msk;
    end

    // read selection; an unmapped address matches no select and reads zero
    assign rdata = ({32{sel_start}} & start_word)
                 | ({32{sel_csr}}   & csr_word)
                 | ({32{sel_count}} & count_word)
                 | ({32{sel_const}} & const_word)
                 | ({32{sel_ist}}   & ist_word)
                 | ({32{sel_imsk}}  & imsk_word);

    // handshake: ack marks the answer cycle of each request
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            ack <= 1'b0;
        end else begin
            ack <= access;
        end
    end

    // read data taken on the request cycle, so it stands at the answer edge
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            avs_readdata_o <= 32'h0000_0000;
        end else if (access && req.read) begin
            avs_readdata_o <= rdata;
        end
    end

    // count run bit; halting keeps both the count and the prescaler phase
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            run_bit <= 1'b0;
        end else if (wr_start) begin
            run_bit <= req.writedata[RUN_BIT];
        end
    end

    // reserved start bit, kept so software reads back what it wrote
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            start_rsv <= 1'b0;
        end else if (wr_start) begin
            start_rsv <= req.writedata[START_RSV];
        end
    end

    // reserved control/status bit
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            csr_rsv <= 1'b0;
        end else if (wr_csr) begin
            csr_rsv <= req.writedata[CSR_RSV];
        end
    end

    // clock select; a change mid-count acts at once because the prescaler compares with >=
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            cks <= CKS_D4;
        end else if (wr_csr) begin
            cks <= req.writedata[CKS_HI:CKS_LO];
        end
    end

    // match flag: a new match wins over a clear in the same cycle
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            flag <= 1'b0;
        end else if (match) begin
            flag <= 1'b1;
        end else if (flag_clr) begin
            flag <= 1'b0;
        end
    end

    // read-before-clear guard; every match disarms it, so a fresh read is needed
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            flag_seen <= 1'b0;
        end else if (match || flag_clr) begin
            flag_seen <= 1'b0;
        end else if (rd_csr && flag) begin
            flag_seen <= 1'b1;
        end
    end

    // prescaler; halting keeps the phase, so a restart loses no part period
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            pre <= 6'h00;
        end else if (counting) begin
            pre <= next_pre;
        end
    end

    // counter; a software write overrides a tick in the same cycle
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            count <= COUNT_RST[CNT_W-1:0];
        end else if (wr_count) begin
            count <= req.writedata[CNT_W-1:0];
        end else if (tick) begin
            count <= next_count;
        end
    end

    // compare constant; standby leaves it alone
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            cmp_const <= CONST_RST[CNT_W-1:0];
        end else if (wr_const) begin
            cmp_const <= req.writedata[CNT_W-1:0];
        end
    end

    // dma request: one registered pulse per match, free of decode glitches
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            dma_req <= 1'b0;
        end else begin
            dma_req <= match;
        end
    end

    // interrupt status: a match wins over a write-one clear
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            irq_st <= 1'b0;
        end else if (match) begin
            irq_st <= 1'b1;
        end else if (irq_clr) begin
            irq_st <= 1'b0;
        end
    end

    // interrupt mask
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            irq_msk <= 1'b0;
        end else if (wr_imsk) begin
            irq_msk <= req.writedata[IRQ_MATCH];
        end
    end

    // outputs; the interrupt level follows status and mask with no extra delay
    assign dma_req_o = dma_req;
    assign irq_o     = irq_st & irq_msk;
endmodule : mtmr_top
